// file: core/fwr_pkg.sv
/*
 Shared constants, types and command codes for the flash wrap, reset
 and parameter-table command block.
 Assumes a host that drives chip select, serial clock and four data lines.
*/
package fwr_pkg;

	// Command codes
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_WRAP_READ = 8'h0C;
	localparam logic [7:0] OP_SET_PARAM = 8'hC0;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_DISC_READ = 8'h5A;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_QIO_READ = 8'hEB;
	localparam logic [7:0] OP_WORD_READ = 8'hE7;
	localparam logic [7:0] OP_ENTER_4W = 8'h38;
	localparam logic [7:0] OP_EXIT_4W = 8'hFF;

	// Phase lengths in bits
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] WRAP_ARG_BITS = 6'h20;
	localparam logic [5:0] PARAM_ARG_BITS = 6'h08;

	// Argument field positions
	localparam int WRAP_DIS_POS = 4;
	localparam int WRAP_SIZE_LSB = 5;
	localparam int DUMMY_SEL_LSB = 4;
	localparam int BURST_SEL_LSB = 0;

	// Dummy clock counts
	localparam logic [3:0] DUMMY_DISC = 4'h8;
	localparam logic [3:0] DUMMY_FAST_STD = 4'h8;
	localparam logic [3:0] DUMMY_QIO_STD = 4'h6;
	localparam logic [3:0] DUMMY_WORD_STD = 4'h4;
	localparam logic [3:0] DUMMY_SEL_LO = 4'h4;
	localparam logic [3:0] DUMMY_SEL_MID = 4'h6;
	localparam logic [3:0] DUMMY_SEL_HI = 4'h8;

	// Wrap section and parameter area
	localparam logic [7:0] SECT_MIN = 8'h08;
	localparam int DISC_AW = 11;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [31:0] DISC_SIGNATURE = 32'h50444653;
	localparam logic [7:0] DISC_REV_MINOR = 8'h01;
	localparam logic [7:0] DISC_REV_MAJOR = 8'h01;
	localparam logic [7:0] DISC_HDR_COUNT = 8'h00;
	localparam logic [7:0] DISC_TBL_MINOR = 8'h00;
	localparam logic [7:0] DISC_TBL_MAJOR = 8'h01;
	localparam logic [7:0] DISC_TBL_LEN = 8'h04;
	localparam logic [23:0] DISC_TBL_PTR = 24'h000080;

	// Recovery timing
	localparam int T_RST_NS = 30000;
	localparam int MCLK_NS = 50;
	localparam int RST_CYCLES = (T_RST_NS + MCLK_NS - 1) / MCLK_NS;

	typedef struct packed {
		logic four_wire;
		logic wrap_disable_bit;
		logic [1:0] wrap_size_field;
		logic [1:0] dummy_count_select;
		logic [1:0] burst_size_select;
	} fwr_cfg_t;

	localparam fwr_cfg_t CFG_RST = '{
		four_wire: 1'b0,
		wrap_disable_bit: 1'b1,
		wrap_size_field: 2'h0,
		dummy_count_select: 2'h0,
		burst_size_select: 2'h0
	};

	typedef enum logic [2:0] {
		ST_OPC = 3'b000,
		ST_ARG = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA = 3'b100,
		ST_SKIP = 3'b101
	} fwr_state_t;

endpackage : fwr_pkg

// file: core/fwr_flash_cmd.sv
/*
 Command interpreter for wrap setting, wrapped reads, read parameters,
 the two-step software reset and the parameter-table read.
 Assumes the array answers i_array_data combinationally from
 o_array_addr; the link side runs on the host's serial clock.
*/
module fwr_flash_cmd #(
	parameter int RECOVERY_CYCLES = fwr_pkg::RST_CYCLES,
	// Arbitrary vendor code reported in the table header
	parameter logic [7:0] VENDOR_CODE = 8'h5C
) (
	// System clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Serial link
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	// Status register input
	input wire logic i_quad_enable,
	// Array read port, link clock
	output logic [23:0] o_array_addr,
	output logic o_array_read,
	input wire logic [7:0] i_array_data,
	// System side status
	output logic o_recovering,
	output logic o_soft_reset,
	output fwr_pkg::fwr_cfg_t o_cfg
);

	localparam int CW = $clog2(RECOVERY_CYCLES + 1);

	generate
		if (RECOVERY_CYCLES < 1)
		begin : g_bad_recovery
			$error("RECOVERY_CYCLES must be at least one");
		end
	endgenerate

	// Frame logic resets while select is high
	logic frm_rst_n;
	assign frm_rst_n = i_resetn & ~i_cs_n;

	logic [1:0] qe_s_r;
	logic [1:0] done_s_r;
	fwr_pkg::fwr_cfg_t cfg_r;
	logic rst_en_r;
	logic lock_r;
	logic swr_tgl_r;
	fwr_pkg::fwr_state_t st_r;
	logic [5:0] cnt_r;
	logic [31:0] sh_r;
	logic [7:0] opc_r;
	logic qin_r;
	logic qout_r;
	logic [3:0] dcnt_r;
	logic [23:0] addr_r;
	logic [2:0] bit_r;
	logic wrap_r;
	logic [1:0] sel_r;
	logic disc_r;
	logic [2:0] swr_s_r;
	logic [CW-1:0] rec_cnt_r;
	logic rec_r;
	logic soft_r;
	logic done_tgl_r;
	fwr_pkg::fwr_cfg_t cfg_s1_r;
	fwr_pkg::fwr_cfg_t cfg_s2_r;
	fwr_pkg::fwr_cfg_t cfg_s3_r;
	fwr_pkg::fwr_cfg_t cfg_o_r;

	logic qe;
	logic done_s;
	logic lanes_in;
	logic [31:0] sh_nxt;
	logic [5:0] cnt_nxt;
	logic opc_done;
	logic [7:0] opc;
	logic accept;
	logic [5:0] arg_bits;
	logic arg_done;
	logic [3:0] param_dummy;
	logic [7:0] mask;
	logic [7:0] low_inc;
	logic [23:0] addr_nxt;
	logic [3:0] step;
	logic byte_end;
	logic [7:0] byte_v;

	assign qe = qe_s_r[1];
	assign done_s = done_s_r[1];

	// Opcode always arrives at the current mode's width
	assign lanes_in = (st_r == fwr_pkg::ST_OPC) ? cfg_r.four_wire : qin_r;
	assign sh_nxt = lanes_in ? {sh_r[27:0], i_io} : {sh_r[30:0], i_io[0]};
	assign cnt_nxt = cnt_r + (lanes_in ? 6'h04 : 6'h01);
	assign opc_done = (st_r == fwr_pkg::ST_OPC) && (cnt_nxt == fwr_pkg::OPC_BITS);
	assign opc = sh_nxt[7:0];
	assign accept = opc_done & ~lock_r;
	assign arg_bits = (opc_r == fwr_pkg::OP_SET_WRAP) ? fwr_pkg::WRAP_ARG_BITS : fwr_pkg::PARAM_ARG_BITS;
	assign arg_done = (st_r == fwr_pkg::ST_ARG) && (cnt_nxt == arg_bits);

	always_comb
	begin
		unique case (cfg_r.dummy_count_select)
			2'h2: param_dummy = fwr_pkg::DUMMY_SEL_MID;
			2'h3: param_dummy = fwr_pkg::DUMMY_SEL_HI;
			default: param_dummy = fwr_pkg::DUMMY_SEL_LO;
		endcase
	end

	// low bits count modulo section length
	assign mask = (fwr_pkg::SECT_MIN << sel_r) - 8'h01;
	assign low_inc = addr_r[7:0] + 8'h01;
	assign addr_nxt = wrap_r ? {addr_r[23:8], (addr_r[7:0] & ~mask) | (low_inc & mask)} : addr_r + 24'h000001;

	assign step = qout_r ? 4'h4 : 4'h1;
	assign byte_end = ({1'b0, bit_r} + step) == 4'h8;

	// parameter area, blanks read as erased
	function automatic logic [7:0] disc_byte(input logic [23:0] a);
		logic [7:0] d;
		d = fwr_pkg::BLANK_BYTE;
		if (a[23:fwr_pkg::DISC_AW] == '0)
		begin
			unique case (a[7:0])
				8'h00: d = fwr_pkg::DISC_SIGNATURE[7:0];
				8'h01: d = fwr_pkg::DISC_SIGNATURE[15:8];
				8'h02: d = fwr_pkg::DISC_SIGNATURE[23:16];
				8'h03: d = fwr_pkg::DISC_SIGNATURE[31:24];
				8'h04: d = fwr_pkg::DISC_REV_MINOR;
				8'h05: d = fwr_pkg::DISC_REV_MAJOR;
				8'h06: d = fwr_pkg::DISC_HDR_COUNT;
				8'h08: d = VENDOR_CODE;
				8'h09: d = fwr_pkg::DISC_TBL_MINOR;
				8'h0A: d = fwr_pkg::DISC_TBL_MAJOR;
				8'h0B: d = fwr_pkg::DISC_TBL_LEN;
				8'h0C: d = fwr_pkg::DISC_TBL_PTR[7:0];
				8'h0D: d = fwr_pkg::DISC_TBL_PTR[15:8];
				8'h0E: d = fwr_pkg::DISC_TBL_PTR[23:16];
				default: d = fwr_pkg::BLANK_BYTE;
			endcase
			if (a[10:8] != 3'h0)
			begin
				d = fwr_pkg::BLANK_BYTE;
			end
		end
		return d;
	endfunction : disc_byte

	assign byte_v = disc_r ? disc_byte(addr_r) : i_array_data;

	// Status bit synchroniser on the link clock
	always_ff @(posedge i_sclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			qe_s_r <= 2'h0;
			done_s_r <= 2'h0;
		end
		else
		begin
			qe_s_r <= {qe_s_r[0], i_quad_enable};
			done_s_r <= {done_s_r[0], done_tgl_r};
		end
	end

	// Volatile settings survive frames
	always_ff @(posedge i_sclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cfg_r <= fwr_pkg::CFG_RST;
			rst_en_r <= 1'b0;
			lock_r <= 1'b0;
			swr_tgl_r <= 1'b0;
		end
		else
		begin
			// Done toggle catches up; no need to clock during recovery
			if (lock_r && (done_s == swr_tgl_r))
			begin
				lock_r <= 1'b0;
			end
			if (accept)
			begin
				rst_en_r <= (opc == fwr_pkg::OP_RST_EN);
				unique case (opc)
					fwr_pkg::OP_RST:
					begin
						if (rst_en_r)
						begin
							cfg_r <= fwr_pkg::CFG_RST;
							lock_r <= 1'b1;
							swr_tgl_r <= ~swr_tgl_r;
						end
					end
					fwr_pkg::OP_ENTER_4W:
					begin
						if (!cfg_r.four_wire && qe)
						begin
							cfg_r.four_wire <= 1'b1;
						end
					end
					fwr_pkg::OP_EXIT_4W:
					begin
						if (cfg_r.four_wire)
						begin
							cfg_r.four_wire <= 1'b0;
						end
					end
					default:
					begin
					end
				endcase
			end
			if (arg_done)
			begin
				if (opc_r == fwr_pkg::OP_SET_WRAP)
				begin
					cfg_r.wrap_disable_bit <= sh_nxt[fwr_pkg::WRAP_DIS_POS];
					cfg_r.wrap_size_field <= sh_nxt[fwr_pkg::WRAP_SIZE_LSB +: 2];
				end
				else
				begin
					cfg_r.dummy_count_select <= sh_nxt[fwr_pkg::DUMMY_SEL_LSB +: 2];
					cfg_r.burst_size_select <= sh_nxt[fwr_pkg::BURST_SEL_LSB +: 2];
				end
			end
		end
	end

	// Frame sequencing, sampled on rising clock
	always_ff @(posedge i_sclk or negedge frm_rst_n)
	begin
		if (!frm_rst_n)
		begin
			st_r <= fwr_pkg::ST_OPC;
			cnt_r <= 6'h00;
			sh_r <= 32'h00000000;
			opc_r <= 8'h00;
			qin_r <= 1'b0;
			qout_r <= 1'b0;
			dcnt_r <= 4'h0;
			addr_r <= 24'h000000;
			bit_r <= 3'h0;
			wrap_r <= 1'b0;
			sel_r <= 2'h0;
			disc_r <= 1'b0;
		end
		else
		begin
			unique case (st_r)
				fwr_pkg::ST_OPC:
				begin
					sh_r <= sh_nxt;
					cnt_r <= cnt_nxt;
					qin_r <= cfg_r.four_wire;
					qout_r <= cfg_r.four_wire;
					if (opc_done)
					begin
						cnt_r <= 6'h00;
						opc_r <= opc;
						st_r <= fwr_pkg::ST_SKIP;
						if (accept)
						begin
							unique case (opc)
								fwr_pkg::OP_SET_WRAP:
								begin
									if (qe)
									begin
										st_r <= fwr_pkg::ST_ARG;
									end
								end
								fwr_pkg::OP_SET_PARAM:
								begin
									if (cfg_r.four_wire)
									begin
										st_r <= fwr_pkg::ST_ARG;
									end
								end
								fwr_pkg::OP_WRAP_READ:
								begin
									if (cfg_r.four_wire)
									begin
										st_r <= fwr_pkg::ST_ADDR;
										wrap_r <= 1'b1;
										sel_r <= cfg_r.burst_size_select;
										dcnt_r <= param_dummy;
									end
								end
								fwr_pkg::OP_FAST_READ:
								begin
									st_r <= fwr_pkg::ST_ADDR;
									dcnt_r <= cfg_r.four_wire ? param_dummy : fwr_pkg::DUMMY_FAST_STD;
								end
								fwr_pkg::OP_QIO_READ:
								begin
									if (cfg_r.four_wire || qe)
									begin
										st_r <= fwr_pkg::ST_ADDR;
										qin_r <= 1'b1;
										qout_r <= 1'b1;
										wrap_r <= ~cfg_r.wrap_disable_bit;
										sel_r <= cfg_r.wrap_size_field;
										dcnt_r <= cfg_r.four_wire ? param_dummy : fwr_pkg::DUMMY_QIO_STD;
									end
								end
								fwr_pkg::OP_WORD_READ:
								begin
									if (!cfg_r.four_wire && qe)
									begin
										st_r <= fwr_pkg::ST_ADDR;
										qin_r <= 1'b1;
										qout_r <= 1'b1;
										wrap_r <= ~cfg_r.wrap_disable_bit;
										sel_r <= cfg_r.wrap_size_field;
										dcnt_r <= fwr_pkg::DUMMY_WORD_STD;
									end
								end
								fwr_pkg::OP_DISC_READ:
								begin
									st_r <= fwr_pkg::ST_ADDR;
									disc_r <= 1'b1;
									dcnt_r <= fwr_pkg::DUMMY_DISC;
								end
								default:
								begin
								end
							endcase
						end
					end
				end
				fwr_pkg::ST_ARG:
				begin
					sh_r <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (arg_done)
					begin
						st_r <= fwr_pkg::ST_SKIP;
					end
				end
				fwr_pkg::ST_ADDR:
				begin
					sh_r <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == fwr_pkg::ADDR_BITS)
					begin
						addr_r <= sh_nxt[23:0];
						st_r <= fwr_pkg::ST_DUMMY;
					end
				end
				fwr_pkg::ST_DUMMY:
				begin
					dcnt_r <= dcnt_r - 4'h1;
					if (dcnt_r == 4'h1)
					begin
						st_r <= fwr_pkg::ST_DATA;
						bit_r <= 3'h0;
					end
				end
				fwr_pkg::ST_DATA:
				begin
					bit_r <= bit_r + step[2:0];
					if (byte_end)
					begin
						addr_r <= addr_nxt;
					end
				end
				fwr_pkg::ST_SKIP:
				begin
				end
				default:
				begin
					st_r <= fwr_pkg::ST_SKIP;
				end
			endcase
		end
	end

	// drive on falling clock, MSB first
	always_ff @(negedge i_sclk or negedge frm_rst_n)
	begin
		if (!frm_rst_n)
		begin
			o_io <= 4'h0;
			o_io_oe <= 4'h0;
		end
		else if (st_r == fwr_pkg::ST_DATA)
		begin
			if (qout_r)
			begin
				o_io <= bit_r[2] ? byte_v[3:0] : byte_v[7:4];
				o_io_oe <= 4'hF;
			end
			else
			begin
				o_io <= {2'h0, byte_v[3'h7 - bit_r], 1'b0};
				o_io_oe <= 4'h2;
			end
		end
		else
		begin
			o_io <= 4'h0;
			o_io_oe <= 4'h0;
		end
	end

	assign o_array_addr = addr_r;
	assign o_array_read = (st_r == fwr_pkg::ST_DATA) & ~disc_r;

	// Reset event crosses as a toggle
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			swr_s_r <= 3'h0;
			soft_r <= 1'b0;
		end
		else
		begin
			swr_s_r <= {swr_s_r[1:0], swr_tgl_r};
			soft_r <= swr_s_r[2] ^ swr_s_r[1];
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rec_r <= 1'b0;
			rec_cnt_r <= '0;
			done_tgl_r <= 1'b0;
		end
		else if (swr_s_r[2] ^ swr_s_r[1])
		begin
			rec_r <= 1'b1;
			rec_cnt_r <= CW'(RECOVERY_CYCLES - 1);
		end
		else if (rec_r)
		begin
			if (rec_cnt_r == '0)
			begin
				rec_r <= 1'b0;
				done_tgl_r <= ~done_tgl_r;
			end
			else
			begin
				rec_cnt_r <= rec_cnt_r - 1'b1;
			end
		end
	end

	// Word taken only after two equal samples, so a torn word never shows
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cfg_s1_r <= fwr_pkg::CFG_RST;
			cfg_s2_r <= fwr_pkg::CFG_RST;
			cfg_s3_r <= fwr_pkg::CFG_RST;
			cfg_o_r <= fwr_pkg::CFG_RST;
		end
		else
		begin
			cfg_s1_r <= cfg_r;
			cfg_s2_r <= cfg_s1_r;
			cfg_s3_r <= cfg_s2_r;
			if (cfg_s2_r == cfg_s3_r)
			begin
				cfg_o_r <= cfg_s3_r;
			end
		end
	end

	assign o_cfg = cfg_o_r;
	assign o_recovering = rec_r;
	assign o_soft_reset = soft_r;

endmodule : fwr_flash_cmd

// file: bench/fwr_flash_cmd_chk.sv
/*
 Assertions on the wrap, reset and parameter-read command block.
 Bound to fwr_flash_cmd; sees only its ports.
*/
module fwr_flash_cmd_chk #(
	parameter int RECOVERY_CYCLES = 600
) (
	// Clocks and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	// Watched outputs
	input wire logic [3:0] o_io_oe,
	input wire logic [23:0] o_array_addr,
	input wire logic o_array_read,
	input wire logic o_recovering,
	input wire logic o_soft_reset,
	input wire fwr_pkg::fwr_cfg_t o_cfg
);
	timeunit 1ns;
	timeprecision 100ps;

	int rec_cnt_r;
	int idle_cnt_r;

	// Cycles in recovery, cycles deselected
	always_ff @(posedge i_mclk or negedge i_resetn)
		if (!i_resetn)
		begin
			rec_cnt_r <= 0;
			idle_cnt_r <= 0;
		end
		else
		begin
			rec_cnt_r <= o_recovering ? rec_cnt_r + 1 : 0;
			idle_cnt_r <= !i_cs_n ? 0 : (idle_cnt_r < 15 ? idle_cnt_r + 1 : idle_cnt_r);
		end

	sequence s_accept;
		$rose(o_soft_reset) ##0 o_recovering;
	endsequence

	property p_cfg_default;
		@(posedge i_mclk) disable iff (!i_resetn)
		s_accept |-> ##[0:4] (o_cfg == fwr_pkg::CFG_RST);
	endproperty

	property p_wrap_addr;
		@(posedge i_sclk) disable iff (i_cs_n || !i_resetn)
		o_array_read && $past(o_array_read) && (o_array_addr != $past(o_array_addr)) |->
			(o_array_addr == $past(o_array_addr) + 24'h000001) ||
			((o_array_addr[23:6] == $past(o_array_addr[23:6])) && (o_array_addr[5:0] < $past(o_array_addr[5:0])));
	endproperty

	pulse_once_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_soft_reset |=> !o_soft_reset) else $error("soft reset pulse too long");
	reset_recover_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$rose(o_soft_reset) |-> o_recovering) else $error("no recovery at reset");
	recover_len_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$fell(o_recovering) |-> rec_cnt_r >= RECOVERY_CYCLES && rec_cnt_r <= RECOVERY_CYCLES + 2)
		else $error("recovery length wrong");
	cfg_default_a: assert property (p_cfg_default) else $error("settings not default after reset");
	cfg_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_recovering && $past(o_recovering, 5) |-> $stable(o_cfg)) else $error("settings changed in recovery");
	cfg_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$changed(o_cfg) |-> idle_cnt_r < 8 || o_recovering) else $error("settings changed with no command");
	oe_release_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		i_cs_n |-> o_io_oe == 4'h0) else $error("output driven while deselected");
	oe_legal_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_io_oe == 4'h0 || o_io_oe == 4'h2 || o_io_oe == 4'hF) else $error("illegal enable pattern");
	wrap_addr_a: assert property (p_wrap_addr) else $error("address left its section");

endmodule : fwr_flash_cmd_chk

bind fwr_flash_cmd fwr_flash_cmd_chk #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk_u (
	.i_mclk(i_mclk),
	.i_resetn(i_resetn),
	.i_sclk(i_sclk),
	.i_cs_n(i_cs_n),
	.o_io_oe(o_io_oe),
	.o_array_addr(o_array_addr),
	.o_array_read(o_array_read),
	.o_recovering(o_recovering),
	.o_soft_reset(o_soft_reset),
	.o_cfg(o_cfg)
);

// file: bench/fwr_host_model.sv
/*
 Behavioural host controller for the serial link, 32 ns link clock.
 The bench resolves the data wires and feeds them back on i_io.
*/
module fwr_host_model (
	// Link outputs
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_io,
	// Resolved data wires
	input wire logic [3:0] i_io
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end

	// Clock stands still between frames
	task automatic clk(input logic [3:0] v, output logic [3:0] s);
		o_io = v;
		#16 o_sclk = 1'b1;
		s = i_io;
		#16 o_sclk = 1'b0;
	endtask : clk

	// Released lines show the inverse of the last value
	task automatic clocks(input int n);
		logic [3:0] s;
		repeat (n) clk(~o_io, s);
	endtask : clocks

	task automatic put(input logic [7:0] b, input int w);
		logic [3:0] s;
		logic [7:0] t;
		t = b;
		repeat (8 / w)
		begin
			clk(w == 4 ? t[7:4] : {~o_io[3:1], t[7]}, s);
			t = t << w;
		end
	endtask : put

	task automatic get(input int w, output logic [7:0] b);
		logic [3:0] s;
		b = 8'h00;
		repeat (8 / w)
		begin
			clk(~o_io, s);
			b = (w == 4) ? {b[3:0], s} : {b[6:0], s[1]};
		end
	endtask : get

	task automatic start();
		o_cs_n = 1'b0;
		#16;
	endtask : start

	task automatic stop();
		#16 o_cs_n = 1'b1;
		#48;
	endtask : stop

endmodule : fwr_host_model

// file: bench/tb_fwr_flash_cmd.sv
/*
 Self-checking bench for the command block.
 Array data is addr xor A5h; recovery shortened to 200 cycles.
*/
module tb_fwr_flash_cmd;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int REC = 200;
	// Arbitrary vendor code
	localparam logic [7:0] VC = 8'h3C;
	localparam logic [7:0] TBL [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h01, 8'h01, 8'h00, 8'hFF,
		VC, 8'h00, 8'h01, 8'h04, 8'h80, 8'h00, 8'h00, 8'hFF};

	logic i_mclk;
	logic i_resetn;
	logic i_quad_enable;
	logic sclk;
	logic cs_n;
	logic [3:0] host_io;
	logic [3:0] io_w;
	logic [3:0] o_io;
	logic [3:0] o_io_oe;
	logic [23:0] o_array_addr;
	logic o_array_read;
	logic o_recovering;
	logic o_soft_reset;
	fwr_pkg::fwr_cfg_t o_cfg;
	logic [7:0] b;
	logic [23:0] ea;
	int fails = 0;
	int checks_done = 0;
	int resets = 0;
	int cyc = 0;

	assign io_w = (o_io_oe & o_io) | (~o_io_oe & host_io);

	fwr_flash_cmd #(.RECOVERY_CYCLES(REC), .VENDOR_CODE(VC)) dut_u (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_sclk(sclk),
		.i_cs_n(cs_n),
		.i_io(io_w),
		.o_io(o_io),
		.o_io_oe(o_io_oe),
		.i_quad_enable(i_quad_enable),
		.o_array_addr(o_array_addr),
		.o_array_read(o_array_read),
		.i_array_data(o_array_addr[7:0] ^ 8'hA5),
		.o_recovering(o_recovering),
		.o_soft_reset(o_soft_reset),
		.o_cfg(o_cfg)
	);

	fwr_host_model host_u (
		.o_sclk(sclk),
		.o_cs_n(cs_n),
		.o_io(host_io),
		.i_io(io_w)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	always @(negedge i_mclk)
		if (o_soft_reset === 1'b1)
			resets++;

	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask : chk

	task automatic settle();
		repeat (6) @(posedge i_mclk);
		#2;
	endtask : settle

	task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int nb, input int w);
		host_u.start();
		host_u.put(op, w);
		for (int k = 0; k < nb; k++)
			host_u.put(arg[31 - 8 * k -: 8], w);
		host_u.stop();
		settle();
	endtask : cmd

	task automatic rd_start(input logic [7:0] op, input logic [23:0] a, input int nd, input int w, input int wa);
		host_u.start();
		host_u.put(op, w);
		for (int k = 0; k < 3; k++)
			host_u.put(a[23 - 8 * k -: 8], wa);
		host_u.clocks(nd);
	endtask : rd_start

	initial
	begin
		i_resetn = 1'b0;
		i_quad_enable = 1'b0;
		host_u.clocks(4);
		repeat (8) @(posedge i_mclk);
		#2 i_resetn = 1'b1;
		settle();
		chk("cfg_por", 32'h40, o_cfg);
		chk("recov_por", 32'h0, o_recovering);
		rd_start(fwr_pkg::OP_DISC_READ, 24'h000000, 8, 1, 1);
		for (int k = 0; k < 16; k++)
		begin
			host_u.get(1, b);
			chk("table_byte", TBL[k], b);
		end
		chk("table_oe", 32'h2, o_io_oe);
		host_u.stop();
		chk("table_oe_off", 32'h0, o_io_oe);
		rd_start(fwr_pkg::OP_DISC_READ, 24'h0007FE, 8, 1, 1);
		for (int k = 0; k < 2; k++)
		begin
			host_u.get(1, b);
			chk("table_blank", 32'hFF, b);
		end
		host_u.stop();
		cmd(fwr_pkg::OP_SET_WRAP, 32'hAF, 4, 1);
		chk("wrap_no_qe", 32'h40, o_cfg);
		cmd(fwr_pkg::OP_SET_PARAM, 32'h23000000, 1, 1);
		chk("param_std", 32'h40, o_cfg);
		@(posedge i_mclk);
		#2 i_quad_enable = 1'b1;
		cmd(fwr_pkg::OP_SET_WRAP, 32'hAF, 4, 1);
		chk("wrap_on", 32'h10, o_cfg);
		cmd(fwr_pkg::OP_SET_WRAP, 32'h1F, 4, 1);
		chk("wrap_off", 32'h40, o_cfg);
		rd_start(fwr_pkg::OP_QIO_READ, 24'h0000FE, 6, 1, 4);
		for (int k = 0; k < 4; k++)
		begin
			host_u.get(4, b);
			ea = 24'(32'h000000FE + k);
			chk("qio_linear", ea[7:0] ^ 8'hA5, b);
		end
		host_u.stop();
		cmd(fwr_pkg::OP_SET_WRAP, 32'h60, 4, 1);
		chk("wrap_64", 32'h30, o_cfg);
		rd_start(fwr_pkg::OP_QIO_READ, 24'h0000FE, 6, 1, 4);
		for (int k = 0; k < 4; k++)
		begin
			host_u.get(4, b);
			ea = {18'h00003, 6'(6'h3E + k)};
			chk("qio_wrap", ea[7:0] ^ 8'hA5, b);
		end
		host_u.stop();
		cmd(fwr_pkg::OP_ENTER_4W, 32'h0, 0, 1);
		chk("four_wire", 32'hB0, o_cfg);
		cmd(fwr_pkg::OP_SET_PARAM, 32'h23000000, 1, 4);
		chk("param_4w", 32'hBB, o_cfg);
		rd_start(fwr_pkg::OP_WRAP_READ, 24'h0001FC, 6, 4, 4);
		for (int k = 0; k < 6; k++)
		begin
			host_u.get(4, b);
			ea = {18'h00007, 6'(6'h3C + k)};
			chk("wrap_data", ea[7:0] ^ 8'hA5, b);
		end
		chk("wrap_oe", 32'hF, o_io_oe);
		host_u.stop();
		cmd(fwr_pkg::OP_RST_EN, 32'h0, 0, 4);
		cmd(fwr_pkg::OP_SET_PARAM, 32'h23000000, 1, 4);
		cmd(fwr_pkg::OP_RST, 32'h0, 0, 4);
		chk("rst_cancel", 32'h0, resets);
		chk("cfg_kept", 32'hBB, o_cfg);
		chk("busy_clear", 32'h0, o_recovering);
		cmd(fwr_pkg::OP_RST_EN, 32'h0, 0, 4);
		cmd(fwr_pkg::OP_RST, 32'h0, 0, 4);
		chk("rst_pulse", 32'h1, resets);
		chk("recov_on", 32'h1, o_recovering);
		chk("cfg_rst", 32'h40, o_cfg);
		cmd(fwr_pkg::OP_SET_WRAP, 32'h60, 4, 1);
		chk("cfg_locked", 32'h40, o_cfg);
		for (int i = 0; i < 2 * REC && o_recovering !== 1'b0; i++)
			@(posedge i_mclk);
		#2;
		chk("recov_end", 32'h0, o_recovering);
		cmd(fwr_pkg::OP_RST, 32'h0, 0, 1);
		chk("rst_needs_en", 32'h1, resets);
		cmd(fwr_pkg::OP_SET_WRAP, 32'h60, 4, 1);
		chk("cfg_unlocked", 32'h30, o_cfg);
		complete_run();
	end

endmodule : tb_fwr_flash_cmd
